// File: design/scl_defines.svh
`ifndef SCL_DEFINES_SVH
`define SCL_DEFINES_SVH

// Register port geometry
`define SCL_ADDR_W 5
`define SCL_DATA_W 16

// Register offsets
`define SCL_REG_STRAP 5'h12
`define SCL_REG_IMASK 5'h19
`define SCL_REG_ISTAT 5'h1B
`define SCL_REG_CTRL 5'h1F

// Control register fields and reset value
`define SCL_CTRL_INT_POL 14
`define SCL_CTRL_WAKE_SEL 8
`define SCL_CTRL_RST 16'h0000

// Interrupt status bits
`define SCL_IRQ_W 3
`define SCL_IRQ_LATCHED 0
`define SCL_IRQ_RSVD 1
`define SCL_IRQ_WAKE 2

// Operating mode codes
`define SCL_MODE_GMII 4'h1
`define SCL_MODE_NAND 4'h4
`define SCL_MODE_PDOWN 4'h7

// Management address upper bits
`define SCL_ADDR_HI 2'h0

// Serial management frame
`define SCL_PRE_BITS 6'h20
`define SCL_HDR_LAST 6'h0C
`define SCL_DATA_LAST 6'h0F
`define SCL_HDR_ST 12
`define SCL_HDR_OP 11:10
`define SCL_HDR_PHY 9:5
`define SCL_HDR_REG 4:0
`define SCL_OP_READ 2'h2
`define SCL_OP_WRITE 2'h1

// Link speed codes
`define SCL_SPEED_10 2'h0
`define SCL_SPEED_100 2'h1
`define SCL_SPEED_1000 2'h2

`endif

// File: design/scl_pkg.sv
`include "scl_defines.svh"

package scl_pkg;
  typedef logic [`SCL_ADDR_W-1:0] scl_addr_t;
  typedef logic [`SCL_DATA_W-1:0] scl_data_t;
  typedef logic [`SCL_IRQ_W-1:0] scl_irq_t;

  typedef enum logic [3:0] {
    SCL_MD_GMII = `SCL_MODE_GMII,
    SCL_MD_NAND = `SCL_MODE_NAND,
    SCL_MD_PDOWN = `SCL_MODE_PDOWN
  } scl_mode_e;

  typedef struct packed {
    logic led_style_strap;
    logic refclk_out_enable_strap;
    logic [3:0] mode;
    logic [2:0] addr_low;
  } scl_strap_s;

  typedef enum logic [2:0] {
    SCL_MS_PRE = 3'b000,
    SCL_MS_HDR = 3'b001,
    SCL_MS_TA = 3'b010,
    SCL_MS_RD = 3'b011,
    SCL_MS_WR = 3'b100
  } scl_mdio_state_e;
endpackage

// File: design/scl_strap_if.sv
interface scl_strap_if;
  scl_pkg::scl_strap_s strap;
  logic valid;
  modport sampler (output strap, output valid);
  modport core (input strap, input valid);
endinterface

// File: design/scl_strap_sampler.sv
module scl_strap_sampler (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input scl_pkg::scl_strap_s pins_i,
  scl_strap_if.sampler strap_if
);
  import scl_pkg::*;

  // One capture on the first edge after release, then frozen
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_if.strap <= '0;
      strap_if.valid <= 1'b0;
    end else if (!strap_if.valid) begin
      strap_if.strap <= pins_i;
      strap_if.valid <= 1'b1;
    end
  end

  a_capture_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(strap_if.valid) |-> strap_if.strap == $past(pins_i))
    else $error("strap capture differs from pins at release");

  a_strap_frozen: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(strap_if.valid) |-> $stable(strap_if.strap))
    else $error("latched straps changed after capture");
endmodule

// File: design/scl_sync.sv
module scl_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;

  // No reset: the straps must be seen through the whole chip reset
  always_ff @(posedge clk_i) begin
    meta_ff <= d_i;
    q_o <= meta_ff;
  end
endmodule

// File: design/scl_top.sv
// Overview of operation
// - Capture all straps at reset release
// - Upper two address bits always zero
// - Decode mode: normal, NAND tree, power-down
// - Clock strap high enables reference clock in normal mode
// - LED strap picks single or tri-color
// - Interrupt active low unless polarity bit
// - Wake event drives shared pin low
// - Management data follows management clock
// - Straps share receive, LED, clock pins
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`include "scl_defines.svh"

module scl_top #(
  parameter int unsigned BLINK_CYCLES = 5000000
) (
  // Clock and chip reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Register port
  input scl_pkg::scl_addr_t reg_addr_i,
  input scl_pkg::scl_data_t reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output scl_pkg::scl_data_t reg_rdata_o,
  // Serial management pins
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // Shared strap pins
  input wire logic [3:0] rxd_pin_i,
  output logic [3:0] rxd_pin_o,
  output logic rxd_pin_oe_o,
  input wire logic rx_dv_pin_i,
  output logic rx_dv_pin_o,
  output logic rx_dv_pin_oe_o,
  input wire logic rx_clk_pin_i,
  output logic rx_clk_pin_o,
  output logic rx_clk_pin_oe_o,
  input wire logic led2_pin_i,
  output logic led2_pin_o,
  output logic led2_pin_oe_o,
  input wire logic led1_pin_i,
  output logic led1_pin_o,
  output logic led1_pin_oe_o,
  input wire logic refclk_out_pin_i,
  output logic refclk_out_pin_o,
  output logic refclk_out_pin_oe_o,
  // Receive path and status from the transceiver core
  input wire logic [3:0] gmii_rxd_i,
  input wire logic gmii_rx_dv_i,
  input wire logic gmii_rx_clk_i,
  input wire logic refclk_125_i,
  input wire logic link_up_i,
  input wire logic [1:0] link_speed_i,
  input wire logic activity_i,
  input wire logic wol_event_i,
  // Configuration and interrupt
  output scl_pkg::scl_addr_t mgmt_address_o,
  output logic strap_valid_o,
  output logic mode_gmii_o,
  output logic mode_nand_tree_o,
  output logic mode_power_down_o,
  output logic led_single_mode_o,
  output logic irq_or_wake_event_out_o
);
  import scl_pkg::*;

  localparam int BLINK_W = $clog2(BLINK_CYCLES);

  logic rst_meta_ff;
  logic rst_sync_ff;
  scl_strap_s strap_raw;
  scl_strap_s strap_sync;
  logic [1:0] mgmt_sync;
  logic mdc_s;
  logic mdio_s;
  logic mdc_q_ff;
  logic mdc_rise;
  logic latch_evt;
  logic run_ok;
  logic [BLINK_W-1:0] blink_cnt_ff;
  logic blink_ff;
  logic led2_nxt;
  logic led1_nxt;
  logic act_lvl;
  scl_data_t ctrl_ff;
  scl_irq_t imask_ff;
  scl_irq_t istat_ff;
  scl_irq_t nxt_istat;
  scl_irq_t irq_evt;
  scl_irq_t irq_clr;
  logic irq_any;
  logic wr_en;
  scl_addr_t wr_addr;
  scl_data_t wr_data;
  scl_mdio_state_e mstate_ff;
  logic [5:0] mcnt_ff;
  scl_data_t msh_ff;
  logic mrd_ff;
  scl_addr_t mreg_ff;
  logic mwr_ff;
  logic [12:0] hdr;

  scl_strap_if u_strap_if ();

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_sync_ff);

  // Reset release through two flops
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Strap roles of the shared pins
  assign strap_raw.led_style_strap = refclk_out_pin_i;
  assign strap_raw.refclk_out_enable_strap = rx_dv_pin_i;
  assign strap_raw.mode = rxd_pin_i;
  assign strap_raw.addr_low = {rx_clk_pin_i, led2_pin_i, led1_pin_i};

  scl_sync #(.W($bits(scl_strap_s))) u_strap_sync (
    .clk_i(core_clk_i),
    .d_i(strap_raw),
    .q_o(strap_sync)
  );

  scl_sync #(.W(2)) u_mgmt_sync (
    .clk_i(core_clk_i),
    .d_i({mdc_i, mdio_i}),
    .q_o(mgmt_sync)
  );

  assign mdc_s = mgmt_sync[1];
  assign mdio_s = mgmt_sync[0];

  scl_strap_sampler u_sampler (
    .clk_i(core_clk_i),
    .rst_n_i(rst_sync_ff),
    .pins_i(strap_sync),
    .strap_if(u_strap_if.sampler)
  );

  assign latch_evt = u_strap_if.valid && !strap_valid_o;
  // Receive pins are driven only in normal interface mode
  assign run_ok = strap_valid_o && mode_gmii_o;

  // Configuration outputs from the held straps
  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      mgmt_address_o <= '0;
      strap_valid_o <= 1'b0;
      mode_gmii_o <= 1'b0;
      mode_nand_tree_o <= 1'b0;
      mode_power_down_o <= 1'b0;
      led_single_mode_o <= 1'b0;
    end else begin
      mgmt_address_o <= {`SCL_ADDR_HI, u_strap_if.strap.addr_low};
      strap_valid_o <= u_strap_if.valid;
      mode_gmii_o <= u_strap_if.valid && u_strap_if.strap.mode == SCL_MD_GMII;
      mode_nand_tree_o <= u_strap_if.valid && u_strap_if.strap.mode == SCL_MD_NAND;
      mode_power_down_o <= u_strap_if.valid && u_strap_if.strap.mode == SCL_MD_PDOWN;
      led_single_mode_o <= u_strap_if.valid && u_strap_if.strap.led_style_strap;
    end
  end

  // LED blink rate
  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      blink_cnt_ff <= '0;
      blink_ff <= 1'b0;
    end else if (blink_cnt_ff == BLINK_W'(BLINK_CYCLES - 1)) begin
      blink_cnt_ff <= '0;
      blink_ff <= !blink_ff;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + 1'b1;
    end
  end

  // LED pin levels, low lights the LED
  always_comb begin
    act_lvl = activity_i ? blink_ff : 1'b0;
    led2_nxt = 1'b1;
    led1_nxt = 1'b1;
    if (u_strap_if.strap.led_style_strap) begin
      led2_nxt = !link_up_i;
      led1_nxt = activity_i ? blink_ff : 1'b1;
    end else if (link_up_i) begin
      case (link_speed_i)
        `SCL_SPEED_1000: begin
          led2_nxt = act_lvl;
        end
        `SCL_SPEED_100: begin
          led1_nxt = act_lvl;
        end
        `SCL_SPEED_10: begin
          led2_nxt = act_lvl;
          led1_nxt = act_lvl;
        end
        default: begin
          led2_nxt = 1'b1;
          led1_nxt = 1'b1;
        end
      endcase
    end
  end

  // Shared pins stay released until the straps are held
  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rxd_pin_oe_o <= 1'b0;
      rxd_pin_o <= '0;
      rx_dv_pin_oe_o <= 1'b0;
      rx_dv_pin_o <= 1'b0;
      rx_clk_pin_oe_o <= 1'b0;
      rx_clk_pin_o <= 1'b0;
      led2_pin_oe_o <= 1'b0;
      led2_pin_o <= 1'b1;
      led1_pin_oe_o <= 1'b0;
      led1_pin_o <= 1'b1;
      refclk_out_pin_oe_o <= 1'b0;
      refclk_out_pin_o <= 1'b0;
    end else begin
      rxd_pin_oe_o <= run_ok;
      rxd_pin_o <= gmii_rxd_i;
      rx_dv_pin_oe_o <= run_ok;
      rx_dv_pin_o <= gmii_rx_dv_i;
      // Clocks are sampled as levels; a true clock path bypasses this flop
      rx_clk_pin_oe_o <= run_ok;
      rx_clk_pin_o <= gmii_rx_clk_i;
      led2_pin_oe_o <= strap_valid_o;
      led2_pin_o <= led2_nxt;
      led1_pin_oe_o <= strap_valid_o;
      led1_pin_o <= led1_nxt;
      refclk_out_pin_oe_o <= run_ok && u_strap_if.strap.refclk_out_enable_strap;
      refclk_out_pin_o <= refclk_125_i;
    end
  end

  // Register read decode, shared by the port and the serial path
  function automatic scl_data_t reg_read(input scl_addr_t addr);
    scl_data_t d;
    d = '0;
    case (addr)
      `SCL_REG_STRAP: d = `SCL_DATA_W'(u_strap_if.strap);
      `SCL_REG_IMASK: d = `SCL_DATA_W'(imask_ff);
      `SCL_REG_ISTAT: d = `SCL_DATA_W'(istat_ff);
      `SCL_REG_CTRL: d = ctrl_ff;
      default: d = '0;
    endcase
    return d;
  endfunction

  // Port write wins; a serial write in the same cycle is dropped
  assign wr_en = reg_we_i || mwr_ff;
  assign wr_addr = reg_we_i ? reg_addr_i : mreg_ff;
  assign wr_data = reg_we_i ? reg_wdata_i : msh_ff;

  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_re_i ? reg_read(reg_addr_i) : '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ctrl_ff <= `SCL_CTRL_RST;
      imask_ff <= '0;
    end else if (wr_en) begin
      if (wr_addr == `SCL_REG_CTRL) begin
        ctrl_ff <= wr_data;
      end
      if (wr_addr == `SCL_REG_IMASK) begin
        imask_ff <= wr_data[`SCL_IRQ_W-1:0];
      end
    end
  end

  // Sticky events; a new event beats a write-one clear
  always_comb begin
    irq_evt = '0;
    irq_evt[`SCL_IRQ_LATCHED] = latch_evt;
    irq_evt[`SCL_IRQ_RSVD] = latch_evt && !(u_strap_if.strap.mode inside
      {SCL_MD_GMII, SCL_MD_NAND, SCL_MD_PDOWN});
    irq_evt[`SCL_IRQ_WAKE] = wol_event_i;
    irq_clr = (wr_en && wr_addr == `SCL_REG_ISTAT) ? wr_data[`SCL_IRQ_W-1:0] : '0;
    nxt_istat = (istat_ff & ~irq_clr) | irq_evt;
  end

  assign irq_any = |(istat_ff & imask_ff);

  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      istat_ff <= '0;
      irq_or_wake_event_out_o <= 1'b1;
    end else begin
      istat_ff <= nxt_istat;
      if (ctrl_ff[`SCL_CTRL_WAKE_SEL]) begin
        irq_or_wake_event_out_o <= !istat_ff[`SCL_IRQ_WAKE];
      end else begin
        irq_or_wake_event_out_o <= ctrl_ff[`SCL_CTRL_INT_POL] ? irq_any : !irq_any;
      end
    end
  end

  // Serial management: sample on rising management clock
  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      mdc_q_ff <= 1'b0;
    end else begin
      mdc_q_ff <= mdc_s;
    end
  end

  assign mdc_rise = mdc_s && !mdc_q_ff;
  assign hdr = {msh_ff[11:0], mdio_s};

  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      mstate_ff <= SCL_MS_PRE;
      mcnt_ff <= '0;
      msh_ff <= '0;
      mrd_ff <= 1'b0;
      mreg_ff <= '0;
      mwr_ff <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else begin
      mwr_ff <= 1'b0;
      if (mdc_rise) begin
        case (mstate_ff)
          SCL_MS_PRE: begin
            if (mdio_s) begin
              if (mcnt_ff != `SCL_PRE_BITS) begin
                mcnt_ff <= mcnt_ff + 1'b1;
              end
            end else if (mcnt_ff == `SCL_PRE_BITS) begin
              mstate_ff <= SCL_MS_HDR;
              mcnt_ff <= '0;
              msh_ff <= '0;
            end else begin
              mcnt_ff <= '0;
            end
          end
          SCL_MS_HDR: begin
            msh_ff <= {msh_ff[14:0], mdio_s};
            mcnt_ff <= mcnt_ff + 1'b1;
            if (mcnt_ff == `SCL_HDR_LAST) begin
              mcnt_ff <= '0;
              mreg_ff <= hdr[`SCL_HDR_REG];
              mrd_ff <= hdr[`SCL_HDR_OP] == `SCL_OP_READ;
              msh_ff <= reg_read(hdr[`SCL_HDR_REG]);
              if (hdr[`SCL_HDR_ST] && hdr[`SCL_HDR_PHY] == mgmt_address_o &&
                  (hdr[`SCL_HDR_OP] == `SCL_OP_READ || hdr[`SCL_HDR_OP] == `SCL_OP_WRITE)) begin
                mstate_ff <= SCL_MS_TA;
              end else begin
                mstate_ff <= SCL_MS_PRE;
              end
            end
          end
          SCL_MS_TA: begin
            mcnt_ff <= mcnt_ff + 1'b1;
            if (mrd_ff) begin
              mdio_oe_o <= 1'b1;
              mdio_o <= 1'b0;
            end
            if (mcnt_ff != '0) begin
              mcnt_ff <= '0;
              if (mrd_ff) begin
                mdio_o <= msh_ff[15];
                msh_ff <= {msh_ff[14:0], 1'b0};
                mstate_ff <= SCL_MS_RD;
              end else begin
                mstate_ff <= SCL_MS_WR;
              end
            end
          end
          SCL_MS_RD: begin
            mcnt_ff <= mcnt_ff + 1'b1;
            if (mcnt_ff == `SCL_DATA_LAST) begin
              mdio_oe_o <= 1'b0;
              mcnt_ff <= '0;
              mstate_ff <= SCL_MS_PRE;
            end else begin
              mdio_o <= msh_ff[15];
              msh_ff <= {msh_ff[14:0], 1'b0};
            end
          end
          SCL_MS_WR: begin
            msh_ff <= {msh_ff[14:0], mdio_s};
            mcnt_ff <= mcnt_ff + 1'b1;
            if (mcnt_ff == `SCL_DATA_LAST) begin
              mwr_ff <= 1'b1;
              mcnt_ff <= '0;
              mstate_ff <= SCL_MS_PRE;
            end
          end
          default: begin
            mstate_ff <= SCL_MS_PRE;
            mcnt_ff <= '0;
            mdio_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  a_addr_upper_zero: assert property (mgmt_address_o[4:3] == `SCL_ADDR_HI)
    else $error("management address upper bits not zero");

  a_addr_from_pins: assert property (strap_valid_o |->
    mgmt_address_o[2:0] == u_strap_if.strap.addr_low)
    else $error("management address differs from strap");

  a_mode_decode: assert property ($rose(strap_valid_o) |->
    mode_gmii_o == (u_strap_if.strap.mode == SCL_MD_GMII) &&
    mode_power_down_o == (u_strap_if.strap.mode == SCL_MD_PDOWN))
    else $error("operating mode decode wrong");

  a_refclk_gate: assert property (refclk_out_pin_oe_o |->
    u_strap_if.strap.refclk_out_enable_strap && mode_gmii_o)
    else $error("reference clock driven with strap low");

  a_led_single: assert property (strap_valid_o && u_strap_if.strap.led_style_strap &&
    !link_up_i |=> led2_pin_o && led2_pin_oe_o)
    else $error("single LED not off with link down");

  a_int_polarity: assert property (!ctrl_ff[`SCL_CTRL_WAKE_SEL] &&
    !ctrl_ff[`SCL_CTRL_INT_POL] && irq_any |=> !irq_or_wake_event_out_o)
    else $error("interrupt not driven low");

  a_wake_low: assert property (ctrl_ff[`SCL_CTRL_WAKE_SEL] && wol_event_i
    |=> ##1 !irq_or_wake_event_out_o)
    else $error("wake event did not pull pin low");

  a_pins_released: assert property (!strap_valid_o |=> !rxd_pin_oe_o && !led1_pin_oe_o &&
    !rx_dv_pin_oe_o)
    else $error("shared pin driven before straps held");

  a_mdio_drive: assert property (mdio_oe_o |->
    mstate_ff == SCL_MS_TA || mstate_ff == SCL_MS_RD)
    else $error("management data driven outside read");

  a_mdio_release: assert property (mstate_ff == SCL_MS_RD && mcnt_ff == `SCL_DATA_LAST &&
    mdc_rise |=> !mdio_oe_o)
    else $error("management data not released after read");

  a_event_wins: assert property (wol_event_i && irq_clr[`SCL_IRQ_WAKE] |=>
    istat_ff[`SCL_IRQ_WAKE])
    else $error("wake event lost against clear");

  c_normal_mode: cover property ($rose(strap_valid_o) ##1 mode_gmii_o);
  c_mdio_read: cover property (mstate_ff == SCL_MS_RD ##1 mstate_ff == SCL_MS_PRE);
  c_mdio_write: cover property (mwr_ff);
  c_wake_pin: cover property ($fell(irq_or_wake_event_out_o) && ctrl_ff[`SCL_CTRL_WAKE_SEL]);
endmodule

// File: sim/scl_mgmt_model.sv
`include "scl_defines.svh"

module scl_mgmt_model (
  // Core clock paces the management clock
  input wire logic clk_i,
  // Resolved management data line
  input wire logic mdio_i,
  // Management clock and data drive
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Clock rests low between frames
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // Five core cycles a phase leave room for the two-flop sync on the far side
  task automatic bit_cyc(input logic drv, input logic b, output logic s);
    @(posedge clk_i);
    mdc_o <= 1'b0;
    mdio_oe_o <= drv;
    mdio_o <= b;
    repeat (5) @(posedge clk_i);
    s = mdio_i;
    mdc_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic s;
    logic [13:0] hdr;
    logic [17:0] wf;
    logic [17:0] sh;
    hdr = {2'b01, op, phy, rg};
    wf = {2'b10, wd};
    sh = '0;
    for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
    if (op == `SCL_OP_WRITE) begin
      for (int i = 17; i >= 0; i--) bit_cyc(1'b1, wf[i], s);
    end else begin
      // Line released: turnaround zero and data come from the device
      // Two turnaround bits, then sixteen data bits sampled at their own rises
      for (int i = 17; i >= 0; i--) begin
        bit_cyc(1'b0, 1'b1, s);
        sh[i] = s;
      end
    end
    rd = sh[15:0];
    @(posedge clk_i);
    mdc_o <= 1'b0;
    mdio_oe_o <= 1'b0;
  endtask
endmodule

// File: sim/strap_config_latch_bench.sv
`include "scl_defines.svh"

module strap_config_latch_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import scl_pkg::*;

  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  scl_addr_t reg_addr = '0;
  scl_data_t reg_wdata = '0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  scl_data_t reg_rdata;
  logic mdc, mac_o, mac_oe, dut_mdio_o, dut_mdio_oe;
  logic [3:0] s_mode = 4'h0;
  logic s_clk_en = 1'b0;
  logic s_led = 1'b0;
  logic [2:0] s_addr = 3'h0;
  logic [3:0] rxd_o;
  logic rxd_oe, dv_o, dv_oe, rck_o, rck_oe, l2_o, l2_oe, l1_o, l1_oe, ref_o, ref_oe;
  logic [3:0] gmii_rxd = 4'h0;
  logic refclk = 1'b0;
  logic wol = 1'b0;
  logic link = 1'b0;
  scl_addr_t mgmt_addr;
  logic valid, m_gmii, m_nand, m_pd, led_single, irq_pin;
  int n_errors = 0;
  int cmp_count = 0;
  logic [15:0] rd_v;
  logic [8:0] cfgs [5] = '{9'h122, 9'h1BF, 9'h050, 9'h10B, 9'h08D};

  // Pull-up on the data line; straps show wherever the pin is not driven
  wire logic mdio_w = dut_mdio_oe ? dut_mdio_o : (mac_oe ? mac_o : 1'b1);
  wire logic [3:0] rxd_w = rxd_oe ? rxd_o : s_mode;
  wire logic dv_w = dv_oe ? dv_o : s_clk_en;
  wire logic rck_w = rck_oe ? rck_o : s_addr[2];
  wire logic l2_w = l2_oe ? l2_o : s_addr[1];
  wire logic l1_w = l1_oe ? l1_o : s_addr[0];
  wire logic ref_w = ref_oe ? ref_o : s_led;

  always #5 core_clk = ~core_clk;

  scl_mgmt_model i_mac (.clk_i(core_clk), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(mac_o),
    .mdio_oe_o(mac_oe));

  scl_top #(.BLINK_CYCLES(4)) i_dut (
    .core_clk_i(core_clk), .reset_n_i(reset_n),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
    .reg_rdata_o(reg_rdata),
    .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(dut_mdio_o), .mdio_oe_o(dut_mdio_oe),
    .rxd_pin_i(rxd_w), .rxd_pin_o(rxd_o), .rxd_pin_oe_o(rxd_oe),
    .rx_dv_pin_i(dv_w), .rx_dv_pin_o(dv_o), .rx_dv_pin_oe_o(dv_oe),
    .rx_clk_pin_i(rck_w), .rx_clk_pin_o(rck_o), .rx_clk_pin_oe_o(rck_oe),
    .led2_pin_i(l2_w), .led2_pin_o(l2_o), .led2_pin_oe_o(l2_oe),
    .led1_pin_i(l1_w), .led1_pin_o(l1_o), .led1_pin_oe_o(l1_oe),
    .refclk_out_pin_i(ref_w), .refclk_out_pin_o(ref_o), .refclk_out_pin_oe_o(ref_oe),
    .gmii_rxd_i(gmii_rxd), .gmii_rx_dv_i(1'b0), .gmii_rx_clk_i(1'b0), .refclk_125_i(refclk),
    .link_up_i(link), .link_speed_i(2'h0), .activity_i(1'b0), .wol_event_i(wol),
    .mgmt_address_o(mgmt_addr), .strap_valid_o(valid), .mode_gmii_o(m_gmii),
    .mode_nand_tree_o(m_nand), .mode_power_down_o(m_pd), .led_single_mode_o(led_single),
    .irq_or_wake_event_out_o(irq_pin));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input scl_addr_t a, input scl_data_t d);
    @(posedge core_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask

  // Read data stand only in the cycle after the taken edge
  task automatic rd(input scl_addr_t a, output scl_data_t d);
    @(posedge core_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic pulse_wake();
    @(posedge core_clk);
    wol <= 1'b1;
    @(posedge core_clk);
    wol <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic do_reset(input logic [8:0] c);
    logic [3:0] m;
    logic normal;
    logic rsvd;
    m = c[6:3];
    normal = (m == `SCL_MODE_GMII);
    rsvd = !(normal || m == `SCL_MODE_NAND || m == `SCL_MODE_PDOWN);
    @(posedge core_clk);
    {s_led, s_clk_en, s_mode, s_addr} <= c;
    reset_n <= 1'b0;
    settle();
    check("pin oe in reset", 16'({rxd_oe, l1_oe, ref_oe}), 16'h0);
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    check("address", 16'(mgmt_addr), {11'h0, `SCL_ADDR_HI, c[2:0]});
    check("valid", 16'(valid), 16'h1);
    check("modes", 16'({m_gmii, m_nand, m_pd}), 16'({normal, m == 4'h4, m == 4'h7}));
    check("led style", 16'(led_single), 16'(c[8]));
    check("refclk oe", 16'(ref_oe), 16'(c[7] & normal));
    check("rx pins oe", 16'({rxd_oe, dv_oe, rck_oe}), 16'({3{normal}}));
    check("led idle", 16'({l2_oe, l1_oe, l2_o, l1_o}), 16'h000F);
    rd(`SCL_REG_STRAP, rd_v);
    check("strap reg", rd_v, {7'h0, c});
    rd(`SCL_REG_ISTAT, rd_v);
    check("status", rd_v, {14'h0, rsvd, 1'b1});
  endtask

  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  initial begin
    for (int i = 0; i < 5; i++) do_reset(cfgs[i]);
    // Straps move after capture; held values and pin roles must not follow them
    {s_led, s_clk_en, s_mode, s_addr} <= 9'h122;
    gmii_rxd <= 4'hA;
    refclk <= 1'b1;
    link <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check("held address", 16'(mgmt_addr), 16'h0005);
    check("rxd pin", 16'({rxd_oe, rxd_o}), 16'h001A);
    check("refclk pin", 16'(ref_o), 16'h1);
    check("led pin oe", 16'({l2_oe, l1_oe}), 16'h3);
    check("led tri link 10", 16'({l2_o, l1_o}), 16'h0);
    check("rx dv clk pins", 16'({dv_oe, dv_o, rck_oe, rck_o}), 16'hA);
    rd(`SCL_REG_STRAP, rd_v);
    check("held strap reg", rd_v, 16'h008D);
    rd(`SCL_REG_CTRL, rd_v);
    check("ctrl reset", rd_v, `SCL_CTRL_RST);
    rd(5'h03, rd_v);
    check("unmapped", rd_v, 16'h0000);
    check("irq idle", 16'(irq_pin), 16'h1);
    wr(`SCL_REG_IMASK, 16'h0004);
    pulse_wake();
    check("irq low", 16'(irq_pin), 16'h0);
    rd(`SCL_REG_ISTAT, rd_v);
    check("wake status", rd_v, 16'h0005);
    wr(`SCL_REG_CTRL, 16'h4000);
    settle();
    check("irq high pol", 16'(irq_pin), 16'h1);
    wr(`SCL_REG_ISTAT, 16'h0004);
    settle();
    check("irq cleared", 16'(irq_pin), 16'h0);
    wr(`SCL_REG_IMASK, 16'h0000);
    wr(`SCL_REG_CTRL, 16'h0000);
    pulse_wake();
    check("irq masked", 16'(irq_pin), 16'h1);
    wr(`SCL_REG_CTRL, 16'h0100);
    settle();
    check("wake low", 16'(irq_pin), 16'h0);
    wr(`SCL_REG_ISTAT, 16'h0004);
    settle();
    check("wake released", 16'(irq_pin), 16'h1);
    // Wake event and its clear meet in one cycle: the event must survive
    @(posedge core_clk);
    {reg_we, wol} <= 2'b11;
    reg_addr <= `SCL_REG_ISTAT;
    reg_wdata <= 16'h0004;
    @(posedge core_clk);
    {reg_we, wol} <= 2'b00;
    rd(`SCL_REG_ISTAT, rd_v);
    check("set beats clear", rd_v, 16'h0005);
    check("wake low again", 16'(irq_pin), 16'h0);
    wr(`SCL_REG_CTRL, 16'h0000);
    i_mac.frame(`SCL_OP_READ, 5'h05, `SCL_REG_STRAP, 16'h0000, rd_v);
    check("serial read", rd_v, 16'h008D);
    i_mac.frame(`SCL_OP_READ, 5'h06, `SCL_REG_STRAP, 16'h0000, rd_v);
    check("foreign address", rd_v, 16'hFFFF);
    i_mac.frame(`SCL_OP_WRITE, 5'h05, `SCL_REG_IMASK, 16'h0003, rd_v);
    repeat (4) @(posedge core_clk);
    rd(`SCL_REG_IMASK, rd_v);
    check("serial write", rd_v, 16'h0003);
    check("irq latched bit", 16'(irq_pin), 16'h0);
    summarize();
  end
endmodule
